// *** design/i2c_mode_ctrl.sv ***
// top: mode bits, ack check, start/stop issue and bus busy tracking
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module i2c_mode_ctrl (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_scl_oe,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_arb_lost,
  input wire logic i_addr_match,
  input wire logic i_rw_bit,
  input wire logic i_ack_valid,
  input wire logic i_ack_bit,
  input wire logic i_xfer_active,
  output logic o_master_select,
  output logic o_transmit_select,
  output logic [1:0] o_mode,
  output logic o_ack_check_enable,
  output logic o_received_ack_value,
  output logic o_halt_transfer,
  output logic o_bus_busy_flag,
  output logic o_cond_busy
);
  bus_line_if lines ();

  bus_line_monitor u_mon (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .lines(lines.mon)
  );

  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic mst_q, mst_d, mst_lock_q, mst_lock_d;
  logic trs_q, trs_d, trs_al_lock_q, trs_al_lock_d;
  logic trs_hw_lock_q, trs_hw_lock_d;
  logic trs_pend_q, trs_pend_d, trs_pval_q, trs_pval_d;
  logic ack_check_enable_q, ack_check_enable_d, received_ack_value_q, received_ack_value_d;
  logic bus_busy_flag_q, bus_busy_flag_d;
  logic held_q, held_d;
  logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic [i2c_ctl_pkg::COND_CNT_W-1:0] cnt_q, cnt_d;
  i2c_ctl_pkg::cond_state_t st_q, st_d;
  logic access, wr_ctrl, rd_ctrl;
  logic [7:0] wd;
  logic [7:0] ctrl_view;
  logic [1:0] mode;
  logic trs_sw_ok, start_req, stop_req, cnt_done;

  // one access per request: taken while ack is low, answered next cycle
  assign access = i_wb_cyc && i_wb_stb && !ack_q;
  assign wd = i_wb_dat[7:0];
  assign wr_ctrl = access && i_wb_we && i_wb_sel[0]
    && (i_wb_adr == i2c_ctl_pkg::CTRL_OFS);
  assign rd_ctrl = access && !i_wb_we
    && (i_wb_adr == i2c_ctl_pkg::CTRL_OFS);
  assign mode = {mst_q, trs_q};

  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[i2c_ctl_pkg::BIT_MST] = mst_q;
    ctrl_view[i2c_ctl_pkg::BIT_TRS] = trs_q;
    ctrl_view[i2c_ctl_pkg::BIT_ACK_CHECK_ENABLE] = ack_check_enable_q;
    ctrl_view[i2c_ctl_pkg::BIT_BUS_BUSY_FLAG] = bus_busy_flag_q;
    ctrl_view[i2c_ctl_pkg::BIT_SCP] = i2c_ctl_pkg::SCP_READ;
  end

  always_comb begin
    ack_d = access;
    rdat_d = rdat_q;
    if (access && !i_wb_we) begin
      rdat_d = 32'h0000_0000;
      if (i_wb_adr == i2c_ctl_pkg::CTRL_OFS) begin
        rdat_d[7:0] = ctrl_view;
      end else if (i_wb_adr == i2c_ctl_pkg::STAT_OFS) begin
        rdat_d[i2c_ctl_pkg::STAT_RECEIVED_ACK_VALUE] = ack_check_enable_q && received_ack_value_q;
        rdat_d[i2c_ctl_pkg::STAT_BUS_BUSY_FLAG] = bus_busy_flag_q;
        rdat_d[i2c_ctl_pkg::STAT_MODE +: 2] = mode;
        rdat_d[i2c_ctl_pkg::STAT_HELD] = held_q;
      end
    end
  end

  // mode bits; hardware events win over a software write in the same cycle
  always_comb begin
    mst_d = mst_q;
    mst_lock_d = mst_lock_q;
    if (rd_ctrl && !mst_q) begin
      mst_lock_d = 1'b0;
    end
    if (wr_ctrl) begin
      if (!wd[i2c_ctl_pkg::BIT_MST]) begin
        mst_d = 1'b0;
      end else if (!mst_lock_q) begin
        mst_d = 1'b1;
      end
    end
    if (i_arb_lost && mst_q) begin
      mst_d = 1'b0;
      mst_lock_d = 1'b1;
    end
  end

  always_comb begin
    trs_d = trs_q;
    trs_al_lock_d = trs_al_lock_q;
    trs_hw_lock_d = trs_hw_lock_q;
    trs_pend_d = trs_pend_q;
    trs_pval_d = trs_pval_q;
    if (rd_ctrl && !trs_q) begin
      trs_al_lock_d = 1'b0;
    end
    if (rd_ctrl && trs_q) begin
      trs_hw_lock_d = 1'b0;
    end
    trs_sw_ok = wr_ctrl && (wd[i2c_ctl_pkg::BIT_TRS] ?
      !trs_al_lock_q : !trs_hw_lock_q);
    if (trs_sw_ok) begin
      if (i_xfer_active) begin
        trs_pend_d = 1'b1;
        trs_pval_d = wd[i2c_ctl_pkg::BIT_TRS];
      end else begin
        trs_d = wd[i2c_ctl_pkg::BIT_TRS];
        trs_pend_d = 1'b0;
      end
    end else if (trs_pend_q && !i_xfer_active) begin
      trs_d = trs_pval_q;
      trs_pend_d = 1'b0;
    end
    if (i_addr_match && !mst_q && i_rw_bit) begin
      trs_d = 1'b1;
      trs_hw_lock_d = 1'b1;
      trs_pend_d = 1'b0;
    end
    if (i_arb_lost && mst_q) begin
      trs_d = 1'b0;
      trs_al_lock_d = 1'b1;
      trs_pend_d = 1'b0;
    end
  end

  // ack check: with checking off the received value is always recorded as 0
  always_comb begin
    ack_check_enable_d = ack_check_enable_q;
    received_ack_value_d = received_ack_value_q;
    if (wr_ctrl) begin
      ack_check_enable_d = wd[i2c_ctl_pkg::BIT_ACK_CHECK_ENABLE];
    end
    if (i_ack_valid) begin
      received_ack_value_d = ack_check_enable_q && i_ack_bit;
    end
  end

  // bus busy follows only the line conditions, never a register write
  always_comb begin
    bus_busy_flag_d = bus_busy_flag_q;
    if (lines.start_det) begin
      bus_busy_flag_d = 1'b1;
    end else if (lines.stop_det) begin
      bus_busy_flag_d = 1'b0;
    end
  end

  // requests while a condition is in progress are dropped
  assign start_req = wr_ctrl && mst_q && !wd[i2c_ctl_pkg::BIT_SCP]
    && wd[i2c_ctl_pkg::BIT_BUS_BUSY_FLAG];
  assign stop_req = wr_ctrl && mst_q && !wd[i2c_ctl_pkg::BIT_SCP]
    && !wd[i2c_ctl_pkg::BIT_BUS_BUSY_FLAG];
  assign cnt_done = (cnt_q == i2c_ctl_pkg::CNT_ZERO);

  always_comb begin
    st_d = st_q;
    held_d = held_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - i2c_ctl_pkg::CNT_ONE;
    case (st_q)
      i2c_ctl_pkg::CS_IDLE: begin
        if (start_req && held_q) begin
          st_d = i2c_ctl_pkg::CS_RS_SDA;
        end else if (start_req && !bus_busy_flag_q) begin
          st_d = i2c_ctl_pkg::CS_START_SDA;
        end else if (stop_req && held_q) begin
          st_d = i2c_ctl_pkg::CS_SP_SDA;
        end
      end
      i2c_ctl_pkg::CS_START_SDA: begin
        if (cnt_done) begin
          st_d = i2c_ctl_pkg::CS_START_SCL;
        end
      end
      i2c_ctl_pkg::CS_START_SCL: begin
        if (cnt_done) begin
          st_d = i2c_ctl_pkg::CS_IDLE;
          held_d = 1'b1;
        end
      end
      i2c_ctl_pkg::CS_RS_SDA: begin
        if (cnt_done) begin
          st_d = i2c_ctl_pkg::CS_RS_SCL;
        end
      end
      i2c_ctl_pkg::CS_RS_SCL: begin
        if (cnt_done) begin
          st_d = i2c_ctl_pkg::CS_START_SDA;
        end
      end
      i2c_ctl_pkg::CS_SP_SDA: begin
        if (cnt_done) begin
          st_d = i2c_ctl_pkg::CS_SP_SCL;
        end
      end
      i2c_ctl_pkg::CS_SP_SCL: begin
        if (cnt_done) begin
          st_d = i2c_ctl_pkg::CS_SP_REL;
        end
      end
      i2c_ctl_pkg::CS_SP_REL: begin
        if (cnt_done) begin
          st_d = i2c_ctl_pkg::CS_IDLE;
          held_d = 1'b0;
        end
      end
      default: begin
        st_d = i2c_ctl_pkg::CS_IDLE;
      end
    endcase
    // losing arbitration lets go of both lines at once
    if (i_arb_lost && mst_q) begin
      st_d = i2c_ctl_pkg::CS_IDLE;
      held_d = 1'b0;
    end
    if (st_d != st_q) begin
      cnt_d = i2c_ctl_pkg::COND_HOLD_CYC - i2c_ctl_pkg::CNT_ONE;
    end
    case (st_d)
      i2c_ctl_pkg::CS_IDLE: begin
        scl_oe_d = held_d;
        sda_oe_d = 1'b0;
      end
      i2c_ctl_pkg::CS_START_SDA: begin
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b1;
      end
      i2c_ctl_pkg::CS_START_SCL, i2c_ctl_pkg::CS_SP_SDA: begin
        scl_oe_d = 1'b1;
        sda_oe_d = 1'b1;
      end
      i2c_ctl_pkg::CS_RS_SDA: begin
        scl_oe_d = 1'b1;
        sda_oe_d = 1'b0;
      end
      i2c_ctl_pkg::CS_SP_SCL: begin
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b1;
      end
      default: begin
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      mst_q <= i2c_ctl_pkg::MST_RST;
      mst_lock_q <= 1'b0;
      trs_q <= i2c_ctl_pkg::TRS_RST;
      trs_al_lock_q <= 1'b0;
      trs_hw_lock_q <= 1'b0;
      trs_pend_q <= 1'b0;
      trs_pval_q <= 1'b0;
      ack_check_enable_q <= i2c_ctl_pkg::ACK_CHECK_ENABLE_RST;
      received_ack_value_q <= 1'b0;
      bus_busy_flag_q <= i2c_ctl_pkg::BUS_BUSY_FLAG_RST;
      held_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      cnt_q <= i2c_ctl_pkg::CNT_ZERO;
      st_q <= i2c_ctl_pkg::CS_IDLE;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      mst_q <= mst_d;
      mst_lock_q <= mst_lock_d;
      trs_q <= trs_d;
      trs_al_lock_q <= trs_al_lock_d;
      trs_hw_lock_q <= trs_hw_lock_d;
      trs_pend_q <= trs_pend_d;
      trs_pval_q <= trs_pval_d;
      ack_check_enable_q <= ack_check_enable_d;
      received_ack_value_q <= received_ack_value_d;
      bus_busy_flag_q <= bus_busy_flag_d;
      held_q <= held_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      cnt_q <= cnt_d;
      st_q <= st_d;
    end
  end

  // open drain: the pins only ever pull low
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  assign o_scl_oe = scl_oe_q;
  assign o_sda_oe = sda_oe_q;
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;
  assign o_master_select = mst_q;
  assign o_transmit_select = trs_q;
  assign o_mode = mode;
  assign o_ack_check_enable = ack_check_enable_q;
  assign o_received_ack_value = ack_check_enable_q && received_ack_value_q;
  assign o_halt_transfer = ack_check_enable_q && received_ack_value_q;
  assign o_bus_busy_flag = bus_busy_flag_q;
  assign o_cond_busy = (st_q != i2c_ctl_pkg::CS_IDLE);
endmodule
`default_nettype wire

// *** design/i2c_ctl_pkg.sv ***
// package: register map, field positions, reset values and timing
package i2c_ctl_pkg;
  localparam int unsigned ADR_W = 4;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam int unsigned BIT_MST = 5;
  localparam int unsigned BIT_TRS = 4;
  localparam int unsigned BIT_ACK_CHECK_ENABLE = 3;
  localparam int unsigned BIT_BUS_BUSY_FLAG = 2;
  localparam int unsigned BIT_SCP = 0;
  localparam int unsigned STAT_RECEIVED_ACK_VALUE = 0;
  localparam int unsigned STAT_BUS_BUSY_FLAG = 1;
  localparam int unsigned STAT_MODE = 2;
  localparam int unsigned STAT_HELD = 4;
  localparam logic MST_RST = 1'b0;
  localparam logic TRS_RST = 1'b0;
  localparam logic ACK_CHECK_ENABLE_RST = 1'b0;
  localparam logic BUS_BUSY_FLAG_RST = 1'b0;
  localparam logic SCP_READ = 1'b1;
  localparam logic [1:0] MODE_SLAVE_RX = 2'h0;
  localparam logic [1:0] MODE_SLAVE_TX = 2'h1;
  localparam logic [1:0] MODE_MASTER_RX = 2'h2;
  localparam logic [1:0] MODE_MASTER_TX = 2'h3;
  localparam int unsigned MCLK_MHZ = 200;
  localparam int unsigned COND_HOLD_NS = 4000;
  localparam int unsigned COND_CNT_W = 10;
  // least time: round up to whole cycles
  localparam logic [COND_CNT_W-1:0] COND_HOLD_CYC =
    COND_CNT_W'((COND_HOLD_NS * MCLK_MHZ + 999) / 1000);
  localparam logic [COND_CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [COND_CNT_W-1:0] CNT_ONE = 10'h001;
  typedef enum logic [2:0] {
    CS_IDLE, CS_START_SDA, CS_START_SCL, CS_RS_SDA, CS_RS_SCL,
    CS_SP_SDA, CS_SP_SCL, CS_SP_REL
  } cond_state_t;
endpackage

// *** design/bus_line_if.sv ***
// interface: synchronised line levels and detected bus conditions
`timescale 1ns/10ps
`default_nettype none
interface bus_line_if;
  logic scl_level;
  logic sda_level;
  logic start_det;
  logic stop_det;
  modport mon (output scl_level, output sda_level, output start_det,
    output stop_det);
  modport ctl (input scl_level, input sda_level, input start_det,
    input stop_det);
endinterface
`default_nettype wire

// *** design/bus_line_monitor.sv ***
// module: line synchronisers and start/stop condition detector
`timescale 1ns/10ps
`default_nettype none
module bus_line_monitor (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  bus_line_if.mon lines
);
  logic [1:0] scl_meta_q, scl_meta_d;
  logic [1:0] sda_meta_q, sda_meta_d;
  logic scl_prev_q, scl_prev_d;
  logic sda_prev_q, sda_prev_d;
  logic start_q, start_d;
  logic stop_q, stop_d;

  // first stage feeds only the second; edges look at stage two and later
  always_comb begin
    scl_meta_d = {scl_meta_q[0], i_scl};
    sda_meta_d = {sda_meta_q[0], i_sda};
    scl_prev_d = scl_meta_q[1];
    sda_prev_d = sda_meta_q[1];
    start_d = scl_meta_q[1] && scl_prev_q && sda_prev_q
      && !sda_meta_q[1];
    stop_d = scl_meta_q[1] && scl_prev_q && !sda_prev_q
      && sda_meta_q[1];
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      scl_meta_q <= 2'h3;
      sda_meta_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      scl_meta_q <= scl_meta_d;
      sda_meta_q <= sda_meta_d;
      scl_prev_q <= scl_prev_d;
      sda_prev_q <= sda_prev_d;
      start_q <= start_d;
      stop_q <= stop_d;
    end
  end

  assign lines.scl_level = scl_prev_q;
  assign lines.sda_level = sda_prev_q;
  assign lines.start_det = start_q;
  assign lines.stop_det = stop_q;
endmodule
`default_nettype wire

// *** test/bus_device_model.sv ***
// partner: another device on the two wires, open drain pulls only
`timescale 1ns/10ps
`default_nettype none
module bus_device_model (
  output logic o_scl_low,
  output logic o_sda_low
);
  // half period of the 48 ns link clock
  localparam int HALF = 24;
  // released lines float up through the bench pull-up
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  task automatic frame_start();
    o_sda_low = 1'b1;
    #HALF o_scl_low = 1'b1;
    // data held low, clock toggles only inside the frame
    repeat (4) begin
      #HALF o_scl_low = 1'b0;
      #HALF o_scl_low = 1'b1;
    end
  endtask
  task automatic frame_stop();
    #HALF o_scl_low = 1'b0;
    #HALF o_sda_low = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** test/i2c_mode_ctrl_properties.sv ***
// checker: mode bits, ack check and bus condition properties
`timescale 1ns/10ps
`default_nettype none
module i2c_mode_ctrl_properties (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_oe,
  input wire logic i_arb_lost,
  input wire logic i_addr_match,
  input wire logic i_rw_bit,
  input wire logic i_ack_valid,
  input wire logic i_ack_bit,
  input wire logic o_master_select,
  input wire logic o_transmit_select,
  input wire logic [1:0] o_mode,
  input wire logic o_ack_check_enable,
  input wire logic o_received_ack_value,
  input wire logic o_halt_transfer,
  input wire logic o_bus_busy_flag,
  input wire logic o_cond_busy
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  wire logic ctl_wr = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack &&
    i_wb_adr == i2c_ctl_pkg::CTRL_OFS;
  a_arb_clears_mode:
  assert property (i_arb_lost && o_master_select |=>
    !o_master_select && !o_transmit_select) else $error("arb loss kept");
  a_read_sets_tx:
  assert property (i_addr_match && i_rw_bit && !o_master_select |=>
    o_transmit_select) else $error("read request left receive");
  a_mode_decode:
  assert property (o_mode == {o_master_select, o_transmit_select})
    else $error("mode code mismatch");
  a_ack_masked:
  assert property (!o_ack_check_enable |-> !o_received_ack_value)
    else $error("ack shown while check off");
  a_halt_on_nack:
  assert property (i_ack_valid && i_ack_bit && o_ack_check_enable |=>
    o_halt_transfer) else $error("no halt on nack");
  a_busy_on_start:
  assert property ($fell(i_sda) && i_scl |-> ##[1:8] o_bus_busy_flag)
    else $error("start not seen");
  a_free_on_stop:
  assert property ($rose(i_sda) && i_scl |-> ##[1:8] !o_bus_busy_flag)
    else $error("stop not seen");
  a_inhibit_reads_one:
  assert property (o_wb_ack && !i_wb_we &&
    i_wb_adr == i2c_ctl_pkg::CTRL_OFS |-> o_wb_dat[0])
    else $error("inhibit bit read 0");
  a_inhibit_no_cond:
  assert property (ctl_wr && i_wb_dat[0] && !o_cond_busy |=>
    !o_cond_busy [*3]) else $error("condition with inhibit set");
  a_start_issue:
  assert property (ctl_wr && i_wb_dat[2] && !i_wb_dat[0] &&
    o_master_select && !o_cond_busy && !o_bus_busy_flag |->
    ##[1:3] o_sda_oe) else $error("start not driven");
endmodule
bind i2c_mode_ctrl i2c_mode_ctrl_properties i_props (.i_mclk, .i_sys_rst,
  .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .o_wb_dat,
  .o_wb_ack, .i_scl, .i_sda, .o_sda_oe, .i_arb_lost, .i_addr_match,
  .i_rw_bit, .i_ack_valid, .i_ack_bit, .o_master_select,
  .o_transmit_select, .o_mode, .o_ack_check_enable,
  .o_received_ack_value, .o_halt_transfer, .o_bus_busy_flag,
  .o_cond_busy);
`default_nettype wire

// *** test/tb_i2c_mode_ctrl.sv ***
// testbench: register access, mode interlocks and bus conditions
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_mode_ctrl;
  localparam logic [3:0] CTL = i2c_ctl_pkg::CTRL_OFS;
  localparam logic [3:0] STA = i2c_ctl_pkg::STAT_OFS;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, rd;
  logic ack, scl_oe, sda_oe, master_select, transmit_select, ack_check_enable, rav, halt, busy, cbusy;
  logic arb = 1'b0, amatch = 1'b0, rw = 1'b0, ackv = 1'b0, received_ack_value = 1'b0;
  logic xfer = 1'b0;
  logic dscl, dsda;
  logic pscl, psda;
  logic [1:0] mode;
  // wired-and with pull-up; a pin pulls only if enabled and driving 0
  wire logic scl_w = !(scl_oe === 1'b1 && pscl === 1'b0 || dscl);
  wire logic sda_w = !(sda_oe === 1'b1 && psda === 1'b0 || dsda);
  int n_fail = 0;
  int num_checks = 0;
  always #2.5 clk = ~clk;
  i2c_mode_ctrl i_i2c_mode_ctrl (.i_mclk(clk), .i_sys_rst(rst),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_scl(scl_w), .i_sda(sda_w), .o_scl(pscl), .o_scl_oe(scl_oe),
    .o_sda(psda), .o_sda_oe(sda_oe), .i_arb_lost(arb),
    .i_addr_match(amatch), .i_rw_bit(rw), .i_ack_valid(ackv),
    .i_ack_bit(received_ack_value), .i_xfer_active(xfer), .o_master_select(master_select),
    .o_transmit_select(transmit_select), .o_mode(mode),
    .o_ack_check_enable(ack_check_enable), .o_received_ack_value(rav),
    .o_halt_transfer(halt), .o_bus_busy_flag(busy),
    .o_cond_busy(cbusy));
  bus_device_model i_bus_device_model (.o_scl_low(dscl),
    .o_sda_low(dsda));
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  // one classic cycle; the slave sets the pace
  task automatic wb(input logic w, input logic [3:0] a,
      input logic [7:0] d);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (k > 20) chk(32'h0000_0000, 32'h0000_0001);
      if (k > 20) results();
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_on(input bit on_cond, input logic v);
    int k;
    k = 0;
    while ((on_cond ? cbusy : busy) !== v) begin
      @(posedge clk);
      k++;
      if (k > 6000) chk(32'h0000_0000, 32'h0000_0001);
      if (k > 6000) results();
    end
  endtask
  task automatic ack_pulse(input logic b);
    ackv <= 1'b1;
    received_ack_value <= b;
    tick(1);
    ackv <= 1'b0;
    tick(1);
  endtask
  task automatic t_regs();
    wb(0, CTL, 8'h00);
    chk(rd, 32'h0000_0001);
    wb(1, CTL, 8'h08);
    chk(ack_check_enable, 1'b1);
    wb(1, 4'h8, 8'hff);
    wb(0, 4'h8, 8'h00);
    chk(rd, 32'h0000_0000);
    wb(0, CTL, 8'h00);
    chk(rd, 32'h0000_0009);
    ack_pulse(1'b1);
    chk(halt, 1'b1);
    wb(0, STA, 8'h00);
    chk(rd[0], 1'b1);
    wb(1, CTL, 8'h01);
    ack_pulse(1'b1);
    chk({rav, halt}, 2'h0);
    wb(0, STA, 8'h00);
    chk(rd[0], 1'b0);
    $display("test regs done");
  endtask
  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      wb(1, CTL, {2'h0, i[1:0], 4'h1});
      chk(mode, i[1:0]);
      wb(0, CTL, 8'h00);
      chk(rd[5:4], i[1:0]);
    end
    wb(1, CTL, 8'h01);
    chk({master_select, transmit_select}, 2'h0);
    $display("test modes done");
  endtask
  task automatic t_arb();
    wb(1, CTL, 8'h31);
    arb <= 1'b1;
    tick(1);
    arb <= 1'b0;
    tick(1);
    chk({master_select, transmit_select}, 2'h0);
    wb(1, CTL, 8'h31);
    chk({master_select, transmit_select}, 2'h0);
    wb(0, CTL, 8'h00);
    wb(1, CTL, 8'h31);
    chk({master_select, transmit_select}, 2'h3);
    wb(1, CTL, 8'h01);
    $display("test arbitration done");
  endtask
  task automatic t_slave();
    rw <= 1'b1;
    amatch <= 1'b1;
    tick(1);
    amatch <= 1'b0;
    tick(1);
    chk(transmit_select, 1'b1);
    wb(1, CTL, 8'h01);
    chk(transmit_select, 1'b1);
    wb(0, CTL, 8'h00);
    wb(1, CTL, 8'h01);
    chk(transmit_select, 1'b0);
    // mode change must wait for the byte in flight
    xfer <= 1'b1;
    wb(1, CTL, 8'h11);
    chk(transmit_select, 1'b0);
    xfer <= 1'b0;
    tick(3);
    chk(transmit_select, 1'b1);
    wb(1, CTL, 8'h01);
    $display("test slave done");
  endtask
  task automatic t_cond();
    wb(1, CTL, 8'h31);
    wb(1, CTL, 8'h34);
    wait_on(1'b0, 1'b1);
    wait_on(1'b1, 1'b0);
    chk({scl_oe, sda_oe}, 2'h2);
    wb(0, CTL, 8'h00);
    chk(rd[2], 1'b1);
    wb(0, STA, 8'h00);
    chk(rd, 32'h0000_001e);
    wb(1, CTL, 8'h31);
    tick(20);
    chk({cbusy, busy}, 2'h1);
    wb(1, CTL, 8'h30);
    wait_on(1'b0, 1'b0);
    wait_on(1'b1, 1'b0);
    chk({scl_w, sda_w}, 2'h3);
    wb(1, CTL, 8'h01);
    i_bus_device_model.frame_start();
    tick(1);
    wait_on(1'b0, 1'b1);
    wb(1, CTL, 8'h00);
    tick(10);
    chk({busy, sda_oe}, 2'h2);
    i_bus_device_model.frame_stop();
    tick(1);
    wait_on(1'b0, 1'b0);
    $display("test conditions done");
  endtask
  initial begin
    tick(8);
    rst <= 1'b0;
    tick(1);
    t_regs();
    t_modes();
    t_arb();
    t_slave();
    t_cond();
    results();
  end
endmodule
`default_nettype wire
